// ### rtl/link_frame_pkg.sv
// Purpose : Constants and types for the host-side frame link controller
// Assumes : One DWORD per clock on both link directions
// Notes   : Link codes are an abstract stand-in for the coded primitives
//
// Behaviour
// - After EOF, send WTRM until result
// - Send R_RDY when ready to accept payload
// - Send R_IP throughout receiving frame payload
// - Receiver sends R_OK on error-free payload
// - Send SYNC whenever the link side idles
// - Send X_RDY when payload waits to go
// - Frame is SOF, payload, CRC, EOF
// - X_RDY, wait R_RDY, then SOF; R_RDY until SOF
// - Release with SYNC; receiver holds result until SYNC
// - Answer HOLD with HOLDA; resume after HOLDA
// - DMAT ends transfer: send current CRC, EOF
// - CRC is one DWORD right before EOF
// - CRC covers data DWORDs only, not primitives
// - CRC taken on unscrambled content
// - CRC per DWORD; odd word zero padded
// - CRC polynomial is the 32-bit generator
// - CRC seeded 52325032h at frame start
// - At most 2064 DWORDs from SOF to EOF
// - Receiver sends R_ERR on payload error
package link_frame_pkg;

    // ==========================================================
    // CRC and frame length
    localparam logic [31:0] CRC_SEED      = 32'h52325032;
    localparam logic [31:0] CRC_POLY      = 32'h04c11db7;
    localparam int          MAX_DWORDS    = 2064;
    localparam logic [11:0] MAX_DATA      = 12'(MAX_DWORDS - 1);
    localparam logic [11:0] CNT_STEP      = 12'h001;
    localparam logic [15:0] PAD_ZERO      = 16'h0000;
    localparam int          HALF_W        = 16;

    // ==========================================================
    // Link symbol codes, one per DWORD slot
    typedef enum logic [3:0] {
        P_SYNC  = 4'h0,
        P_X_RDY = 4'h1,
        P_R_RDY = 4'h2,
        P_R_IP  = 4'h3,
        P_R_OK  = 4'h4,
        P_R_ERR = 4'h5,
        P_SOF   = 4'h6,
        P_EOF   = 4'h7,
        P_WTRM  = 4'h8,
        P_HOLD  = 4'h9,
        P_HOLDA = 4'ha,
        P_DMAT  = 4'hb,
        P_DATA  = 4'hc
    } prim_t;

    // ==========================================================
    // Controller states
    typedef enum logic [9:0] {
        ST_IDLE = 10'h001,
        ST_XRDY = 10'h002,
        ST_DATA = 10'h004,
        ST_CRC  = 10'h008,
        ST_EOF  = 10'h010,
        ST_WTRM = 10'h020,
        ST_RRDY = 10'h040,
        ST_RIP  = 10'h080,
        ST_RES  = 10'h100,
        ST_SPARE = 10'h200
    } link_state_t;

    typedef struct packed {
        link_state_t st;
        prim_t       prim;
        logic [31:0] data;
        logic [31:0] crc;
        logic [11:0] cnt;
        logic [31:0] held;
        logic        have;
        logic        holding;
        logic        holda;
        logic        ready;
        logic        done;
        logic        good;
        logic [31:0] word;
        logic        word_valid;
        logic        fr_ok;
        logic        fr_bad;
    } ctl_t;

    localparam ctl_t CTL_RESET = '{
        st: ST_IDLE, prim: P_SYNC, data: 32'h0, crc: CRC_SEED,
        cnt: 12'h0, held: 32'h0, have: 1'b0, holding: 1'b0,
        holda: 1'b0, ready: 1'b0, done: 1'b0, good: 1'b0,
        word: 32'h0, word_valid: 1'b0, fr_ok: 1'b0, fr_bad: 1'b0
    };

endpackage : link_frame_pkg

// ### rtl/link_frame_ctl.sv
// Purpose : Host link controller: sends and receives framed payload
// Assumes : Peer link logic runs on the same clock, so no synchroniser
// Notes   : Sits before the scrambler; data words here are plain text
`timescale 1ns/1ps

module link_frame_ctl (
    // Clock and reset
    input  wire logic                    clock_i,
    input  wire logic                    arst_n_i,
    // Link toward the peer
    output link_frame_pkg::prim_t        link_prim_o,
    output logic [31:0]                  link_data_o,
    input  wire link_frame_pkg::prim_t   link_prim_i,
    input  wire logic [31:0]             link_data_i,
    // Outgoing payload
    input  wire logic                    send_req_i,
    input  wire logic                    pay_valid_i,
    input  wire logic [31:0]             pay_data_i,
    input  wire logic                    pay_last_i,
    input  wire logic                    pay_half_i,
    output logic                         pay_ready_o,
    output logic                         tx_done_o,
    output logic                         tx_good_o,
    // Incoming payload
    input  wire logic                    rx_stop_i,
    output logic [31:0]                  rx_word_o,
    output logic                         rx_word_valid_o,
    output logic                         rx_frame_ok_o,
    output logic                         rx_frame_bad_o
);
    import link_frame_pkg::*;

    // ==========================================================
    // CRC step, shared by both directions
    function automatic logic [31:0] crc_step(
        input logic [31:0] crc_in,
        input logic [31:0] dw
    );
        logic [31:0] c;
        logic        fb;
        c  = crc_in;
        fb = 1'b0;
        for (int i = 31; i >= 0; i--) begin
            fb = c[31] ^ dw[i];
            c  = {c[30:0], 1'b0};
            if (fb) begin
                c = c ^ CRC_POLY;
            end
        end
        return c;
    endfunction : crc_step

    // ==========================================================
    // State
    ctl_t        r;
    ctl_t        n;
    logic        accept;
    logic        stop_req;
    logic        rx_good;
    logic [31:0] out_word;

    always_comb begin
        n          = r;
        n.done     = 1'b0;
        n.word_valid = 1'b0;
        n.fr_ok    = 1'b0;
        n.fr_bad   = 1'b0;
        n.ready    = 1'b0;
        accept     = pay_valid_i && r.ready;
        stop_req   = (link_prim_i == P_DMAT);
        rx_good    = r.have && (r.crc == r.held);
        // Odd 16-bit word count: upper half of the final DWORD is zero
        out_word   = (pay_last_i && pay_half_i) ?
                     {PAD_ZERO, pay_data_i[HALF_W-1:0]} : pay_data_i;
        case (r.st)
            ST_IDLE: begin
                n.prim = P_SYNC;
                if (link_prim_i == P_X_RDY) begin
                    // Peer's frame is taken before our own request
                    n.st   = ST_RRDY;
                    n.prim = P_R_RDY;
                end else if (send_req_i) begin
                    n.st   = ST_XRDY;
                    n.prim = P_X_RDY;
                end
            end
            ST_XRDY: begin
                n.prim = P_X_RDY;
                if (link_prim_i == P_R_RDY) begin
                    n.st      = ST_DATA;
                    n.prim    = P_SOF;
                    n.crc     = CRC_SEED;
                    n.cnt     = '0;
                    n.holding = 1'b0;
                    n.holda   = 1'b0;
                    n.ready   = 1'b1;
                end
            end
            ST_DATA: begin
                if (accept) begin
                    n.prim    = P_DATA;
                    n.data    = out_word;
                    n.crc     = crc_step(r.crc, out_word);
                    n.cnt     = r.cnt + CNT_STEP;
                    n.holding = 1'b0;
                    n.holda   = 1'b0;
                    // Length cap leaves one slot for the CRC
                    if (pay_last_i || stop_req ||
                        n.cnt == MAX_DATA) begin
                        n.st = ST_CRC;
                    end else begin
                        n.ready = 1'b1;
                    end
                end else if (stop_req) begin
                    n.prim = P_DATA;
                    n.data = r.crc;
                    n.st   = ST_EOF;
                end else begin
                    // Source starved: send HOLD until a word is taken again; ready waits for HOLDA
                    n.prim    = P_HOLD;
                    n.holding = 1'b1;
                    if (r.holding && link_prim_i == P_HOLDA) begin
                        n.holda = 1'b1;
                    end
                    // No resume before the peer has acknowledged the stall
                    n.ready = r.holding && n.holda;
                end
            end
            ST_CRC: begin
                n.prim = P_DATA;
                n.data = r.crc;
                n.st   = ST_EOF;
            end
            ST_EOF: begin
                n.prim = P_EOF;
                n.st   = ST_WTRM;
            end
            ST_WTRM: begin
                n.prim = P_WTRM;
                if (link_prim_i == P_R_OK || link_prim_i == P_R_ERR) begin
                    n.prim = P_SYNC;
                    n.st   = ST_IDLE;
                    n.done = 1'b1;
                    n.good = (link_prim_i == P_R_OK);
                end
            end
            ST_RRDY: begin
                n.prim = P_R_RDY;
                if (link_prim_i == P_SOF) begin
                    n.st   = ST_RIP;
                    n.prim = P_R_IP;
                    n.crc  = CRC_SEED;
                    n.have = 1'b0;
                end else if (link_prim_i == P_SYNC) begin
                    n.st   = ST_IDLE;
                    n.prim = P_SYNC;
                end
            end
            ST_RIP: begin
                n.prim = P_R_IP;
                if (link_prim_i == P_DATA) begin
                    // One word is held back: the last one is the CRC
                    if (r.have) begin
                        n.word       = r.held;
                        n.word_valid = 1'b1;
                        n.crc        = crc_step(r.crc, r.held);
                    end
                    n.held = link_data_i;
                    n.have = 1'b1;
                end else if (link_prim_i == P_HOLD) begin
                    n.prim = P_HOLDA;
                end else if (link_prim_i == P_EOF) begin
                    n.st     = ST_RES;
                    n.prim   = rx_good ? P_R_OK : P_R_ERR;
                    n.fr_ok  = rx_good;
                    n.fr_bad = !rx_good;
                end else if (link_prim_i == P_SYNC) begin
                    // Peer abandoned the frame
                    n.st     = ST_IDLE;
                    n.prim   = P_SYNC;
                    n.fr_bad = 1'b1;
                end
                if (rx_stop_i && n.prim == P_R_IP) begin
                    n.prim = P_DMAT;
                end
            end
            ST_RES: begin
                if (link_prim_i == P_SYNC) begin
                    n.st   = ST_IDLE;
                    n.prim = P_SYNC;
                end
            end
            default: begin
                n = CTL_RESET;
            end
        endcase
    end

    always_ff @(posedge clock_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            r <= CTL_RESET;
        end else begin
            r <= n;
        end
    end

    // ==========================================================
    // Outputs, all straight from the state register
    assign link_prim_o     = r.prim;
    assign link_data_o     = r.data;
    assign pay_ready_o     = r.ready;
    assign tx_done_o       = r.done;
    assign tx_good_o       = r.good;
    assign rx_word_o       = r.word;
    assign rx_word_valid_o = r.word_valid;
    assign rx_frame_ok_o   = r.fr_ok;
    assign rx_frame_bad_o  = r.fr_bad;

    // ==========================================================
    // Checks
    a_wtrm_wait: assert property (
        @(posedge clock_i) disable iff (!arst_n_i)
        (r.st == ST_WTRM && link_prim_i != P_R_OK &&
         link_prim_i != P_R_ERR) |=> link_prim_o == P_WTRM)
        else $error("WTRM not held while awaiting result");

    a_rrdy_answer: assert property (
        @(posedge clock_i) disable iff (!arst_n_i)
        (r.st == ST_IDLE && link_prim_i == P_X_RDY)
        |=> (link_prim_o == P_R_RDY) [*1] ##1 (r.st == ST_RRDY ||
            r.st == ST_RIP || r.st == ST_IDLE))
        else $error("X_RDY not answered with R_RDY");

    a_rip_steady: assert property (
        @(posedge clock_i) disable iff (!arst_n_i)
        (r.st == ST_RIP && !rx_stop_i && (link_prim_i == P_DATA ||
         link_prim_i == P_HOLDA)) |=> link_prim_o == P_R_IP)
        else $error("R_IP missing during reception");

    a_ok_on_good: assert property (
        @(posedge clock_i) disable iff (!arst_n_i)
        (r.st == ST_RIP && link_prim_i == P_EOF && r.have &&
         r.crc == r.held) |=> (link_prim_o == P_R_OK && rx_frame_ok_o))
        else $error("Good frame not answered with R_OK");

    a_err_on_bad: assert property (
        @(posedge clock_i) disable iff (!arst_n_i)
        (r.st == ST_RIP && link_prim_i == P_EOF && !(r.have &&
         r.crc == r.held)) |=> (link_prim_o == P_R_ERR && rx_frame_bad_o))
        else $error("Bad frame not answered with R_ERR");

    a_idle_sync: assert property (
        @(posedge clock_i) disable iff (!arst_n_i)
        r.st == ST_IDLE |-> link_prim_o == P_SYNC)
        else $error("Idle link not sending SYNC");

    a_sof_after_rrdy: assert property (
        @(posedge clock_i) disable iff (!arst_n_i)
        link_prim_o == P_SOF |-> ($past(link_prim_o) == P_X_RDY &&
            $past(link_prim_i) == P_R_RDY && r.crc == CRC_SEED))
        else $error("SOF sent without R_RDY or seed");

    a_crc_then_eof: assert property (
        @(posedge clock_i) disable iff (!arst_n_i)
        r.st == ST_EOF |-> (link_prim_o == P_DATA &&
            link_data_o == r.crc) ##1 link_prim_o == P_EOF)
        else $error("CRC DWORD not directly before EOF");

    a_release_sync: assert property (
        @(posedge clock_i) disable iff (!arst_n_i)
        (r.st == ST_WTRM && link_prim_i == P_R_OK)
        |=> (link_prim_o == P_SYNC && tx_done_o && tx_good_o))
        else $error("No SYNC release after R_OK");

    a_holda_answer: assert property (
        @(posedge clock_i) disable iff (!arst_n_i)
        (r.st == ST_RIP && link_prim_i == P_HOLD) |=> link_prim_o == P_HOLDA)
        else $error("HOLD not answered with HOLDA");

    a_hold_no_resume: assert property (
        @(posedge clock_i) disable iff (!arst_n_i)
        (r.st == ST_DATA && r.holding && !r.holda) |-> !pay_ready_o)
        else $error("Payload resumed before HOLDA");

    a_dmat_close: assert property (
        @(posedge clock_i) disable iff (!arst_n_i)
        (r.st == ST_DATA && link_prim_i == P_DMAT)
        |-> ##[2:3] link_prim_o == P_EOF)
        else $error("DMAT did not close the frame");

    a_len_limit: assert property (
        @(posedge clock_i) disable iff (!arst_n_i)
        r.cnt <= MAX_DATA)
        else $error("Frame longer than the DWORD limit");

endmodule : link_frame_ctl

// ### verification/link_peer_model.sv
// Purpose : Behavioural device-side peer of the host link controller
// Assumes : Same clock as the controller, one symbol per cycle
// Notes   : Data lines toggle outside data slots so stale data shows
`timescale 1ns/1ps

module link_peer_model (
    // Clock and reset
    input  wire logic                  clock_i,
    input  wire logic                  arst_n_i,
    // Link
    input  wire link_frame_pkg::prim_t prim_i,
    input  wire logic [31:0]           data_i,
    output link_frame_pkg::prim_t      prim_o,
    output logic [31:0]                data_o,
    // Scenario controls
    input  wire logic                  slow_i,
    input  wire logic                  dmat_i,
    input  wire logic                  go_i,
    input  wire logic [3:0]            len_i,
    input  wire logic                  bad_i,
    input  wire logic                  hold_i
);
    import link_frame_pkg::*;
    logic [31:0] crc, prev;
    int          st, n, lim, w;
    logic        have, ok;

    function automatic logic [31:0] step(input logic [31:0] c,
                                         input logic [31:0] d);
        for (int i = 31; i >= 0; i--)
            c = {c[30:0], 1'b0} ^ ({32{c[31] ^ d[i]}} & CRC_POLY);
        return c;
    endfunction : step

    // ==========================================================
    // Receive and transmit sequencing
    always @(posedge clock_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            st = 0;
            prim_o <= P_SYNC;
            data_o <= 32'h0;
        end else begin
            data_o <= ~data_o;
            case (st)
            0: begin
                prim_o <= P_SYNC;
                if (prim_i == P_X_RDY) begin
                    st = 1;
                    w = slow_i ? 4 : 0;
                end else if (go_i && prim_i == P_SYNC) begin
                    st = 4;
                    n = 0;
                    lim = int'(len_i);
                    crc = CRC_SEED;
                    prim_o <= P_X_RDY;
                end
            end
            1: begin
                if (w > 0)
                    w--;
                prim_o <= (w > 0) ? P_SYNC : P_R_RDY;
                if (prim_i == P_SOF) begin
                    st = 2;
                    crc = CRC_SEED;
                    have = 1'b0;
                    prim_o <= P_R_IP;
                end
            end
            2: begin
                prim_o <= dmat_i ? P_DMAT : P_R_IP;
                if (prim_i == P_HOLD)
                    prim_o <= P_HOLDA;
                if (prim_i == P_DATA) begin
                    if (have)
                        crc = step(crc, prev);
                    prev = data_i;
                    have = 1'b1;
                end
                if (prim_i == P_EOF) begin
                    // bad_i also forces an error verdict on receive
                    ok = have && crc == prev && !bad_i;
                    st = 3;
                end
            end
            3: begin
                prim_o <= ok ? P_R_OK : P_R_ERR;
                if (prim_i == P_SYNC) begin
                    st = 0;
                    prim_o <= P_SYNC;
                end
            end
            4: if (prim_i == P_R_RDY) begin
                st = 5;
                prim_o <= P_SOF;
            end
            5: begin
                if (prim_i == P_DMAT && n < lim)
                    lim = n;
                if (hold_i && n == 1 && prim_i != P_HOLDA)
                    prim_o <= P_HOLD;
                else if (n < lim) begin
                    prim_o <= P_DATA;
                    data_o <= 32'h3c690000 + 32'(n);
                    crc = step(crc, 32'h3c690000 + 32'(n));
                    n++;
                end else if (n == lim) begin
                    prim_o <= P_DATA;
                    data_o <= crc ^ {31'h0, bad_i};
                    n++;
                end else begin
                    prim_o <= P_EOF;
                    st = 6;
                end
            end
            default: begin
                prim_o <= P_WTRM;
                if (prim_i == P_R_OK || prim_i == P_R_ERR) begin
                    st = 0;
                    prim_o <= P_SYNC;
                end
            end
            endcase
        end
    end
endmodule : link_peer_model

// ### verification/serial_link_frame_crc_test.sv
// Purpose : Self-checking bench for the host frame link controller
// Assumes : Peer model stands in for the device link layer
// Notes   : Frame limit case alone runs about 2100 cycles
`timescale 1ns/1ps

module serial_link_frame_crc_test;
    import link_frame_pkg::*;
    // ==========================================================
    // Signals
    logic        clock_i = 1'b0;
    logic        arst_n_i = 1'b0;
    prim_t       h_prim, p_prim;
    logic [31:0] h_data, p_data, rx_word, pay_data = 32'h0;
    logic        send_req = 0, pay_valid = 0, pay_last = 0, pay_half = 0;
    logic        rx_stop = 0, slow = 0, dmat = 0, go = 0, bad = 0, hold = 0;
    logic        pay_ready, tx_done, tx_good, rx_wv, rx_ok, rx_bad;
    logic [3:0]  len4 = 4'h0;
    int          err_total = 0, num_checks = 0, cyc = 0;
    logic [31:0] mon_q[$], rq[$];
    logic        saw_holda = 0, saw_dmat = 0;
    typedef struct { bit dev; int len; bit flag, gap, slow, good; } row_t;
    row_t rows[6] = '{'{0, 1, 0, 0, 0, 1}, '{0, 5, 1, 0, 1, 1},
        '{0, 3, 0, 1, 0, 1}, '{1, 3, 0, 0, 0, 1}, '{1, 2, 1, 0, 1, 0},
        '{1, 4, 0, 1, 0, 1}};

    always #25 clock_i = ~clock_i;

    link_frame_ctl u_link_frame_ctl (.clock_i(clock_i), .arst_n_i(arst_n_i),
        .link_prim_o(h_prim), .link_data_o(h_data), .link_prim_i(p_prim),
        .link_data_i(p_data), .send_req_i(send_req), .pay_valid_i(pay_valid),
        .pay_data_i(pay_data), .pay_last_i(pay_last), .pay_half_i(pay_half),
        .pay_ready_o(pay_ready), .tx_done_o(tx_done), .tx_good_o(tx_good),
        .rx_stop_i(rx_stop), .rx_word_o(rx_word), .rx_word_valid_o(rx_wv),
        .rx_frame_ok_o(rx_ok), .rx_frame_bad_o(rx_bad));
    link_peer_model u_link_peer_model (.clock_i(clock_i),
        .arst_n_i(arst_n_i), .prim_i(h_prim), .data_i(h_data),
        .prim_o(p_prim), .data_o(p_data), .slow_i(slow), .dmat_i(dmat),
        .go_i(go), .len_i(len4), .bad_i(bad), .hold_i(hold));

    // ==========================================================
    // Link monitor and hang guard
    always @(posedge clock_i) begin
        cyc++;
        if (h_prim == P_SOF)
            mon_q = {};
        if (h_prim == P_DATA)
            mon_q.push_back(h_data);
        if (h_prim == P_HOLDA || p_prim == P_HOLDA)
            saw_holda = 1'b1;
        if (h_prim == P_DMAT)
            saw_dmat = 1'b1;
        if (rx_wv === 1'b1)
            rq.push_back(rx_word);
        if (cyc == 20000) begin
            err_total++;
            tally_and_finish();
        end
    end

    task automatic chk(input string what, input logic [31:0] seen, exp);
        num_checks++;
        if (seen !== exp) begin
            err_total++;
            $display("wrong value %s expected %h seen %h", what, exp, seen);
        end
    endtask : chk

    task automatic tally_and_finish();
        $display("checks %0d mismatches %0d", num_checks, err_total);
        if (err_total == 0 && num_checks > 0)
            $display("ALL TESTS PASSED");
        else
            $display("TESTS FAILED");
        $finish;
    endtask : tally_and_finish

    // ==========================================================
    // Host sends a frame, peer judges its CRC
    task automatic host_tx(input int len, input bit half, gap,
                           output int n, output logic g);
        int t, gc;
        bit take;
        logic [31:0] e;
        n = 0;
        gc = 0;
        take = 1'b0;
        g = 1'bx;
        send_req = 1'b1;
        for (t = 0; t < 5000; t++) begin
            @(negedge clock_i);
            // Outputs are read half a cycle clear of the edge
            if (take)
                n++;
            if (tx_done === 1'b1) begin
                g = tx_good;
                break;
            end
            if (h_prim == P_X_RDY)
                send_req = 1'b0;
            pay_valid = n < len && !(gap && n == 1 && gc < 4);
            gc += (gap && n == 1) ? 1 : 0;
            pay_data = 32'hc3a50000 + 32'(n);
            pay_last = n == len - 1;
            pay_half = half;
            // Ready stands until the next edge, which takes the word
            take = pay_valid && pay_ready === 1'b1;
        end
        pay_valid = 1'b0;
        chk("data slots", mon_q.size(), n + 1);
        for (int k = 0; k < n && k < mon_q.size(); k++) begin
            e = 32'hc3a50000 + 32'(k);
            if (half && k == n - 1)
                e = e & 32'h0000ffff;
            chk("tx word", mon_q[k], e);
        end
    endtask : host_tx

    // ==========================================================
    // Peer sends a frame, host checks it
    task automatic dev_tx(input int len, input bit b, h, stop,
                          output logic res);
        rq = {};
        len4 = 4'(len);
        bad = b;
        hold = h;
        go = 1'b1;
        res = 1'bx;
        for (int t = 0; t < 300; t++) begin
            @(negedge clock_i);
            if (h_prim == P_R_RDY)
                go = 1'b0;
            rx_stop = stop && rq.size() == 1;
            if (rx_ok === 1'b1 || rx_bad === 1'b1) begin
                res = rx_ok;
                break;
            end
        end
        rx_stop = 1'b0;
        for (int k = 0; k < rq.size(); k++)
            chk("rx word", rq[k], 32'h3c690000 + 32'(k));
    endtask : dev_tx

    initial begin
        int n;
        logic g;
        repeat (8) @(posedge clock_i);
        chk("prim in reset", h_prim, P_SYNC);
        chk("outs in reset", {pay_ready, tx_done, tx_good, rx_wv, rx_ok,
            rx_bad}, 0);
        chk("data in reset", h_data | rx_word, 0);
        @(negedge clock_i);
        arst_n_i = 1'b1;
        repeat (3) @(negedge clock_i);
        chk("idle after reset", h_prim, P_SYNC);
        $display("reset test done");
        foreach (rows[r]) begin
            slow = rows[r].slow;
            saw_holda = 1'b0;
            if (!rows[r].dev) begin
                host_tx(rows[r].len, rows[r].flag, rows[r].gap, n, g);
                chk("tx result", g, rows[r].good);
            end else begin
                dev_tx(rows[r].len, rows[r].flag, rows[r].gap, 0, g);
                chk("rx verdict", g, rows[r].good);
                chk("rx count", rq.size(), rows[r].len);
            end
            chk("holda", saw_holda, rows[r].gap);
            repeat (3) @(negedge clock_i);
            chk("idle", h_prim, P_SYNC);
            $display("row test %0d done", r);
        end
        bad = 1'b1;
        host_tx(2, 0, 0, n, g);
        bad = 1'b0;
        chk("error result", g, 0);
        $display("peer error test done");
        mon_q = {};
        fork
            host_tx(8, 0, 0, n, g);
            begin
                while (mon_q.size() < 3)
                    @(negedge clock_i);
                dmat = 1'b1;
                @(negedge clock_i);
                dmat = 1'b0;
            end
        join
        chk("cut short", n < 8, 1);
        chk("cut result", g, 1);
        $display("peer abort test done");
        saw_dmat = 1'b0;
        dev_tx(10, 0, 0, 1, g);
        chk("dmat sent", saw_dmat, 1);
        chk("stop result", g, 1);
        chk("stop count", rq.size() < 10, 1);
        $display("host abort test done");
        host_tx(2070, 0, 0, n, g);
        chk("limit slots", mon_q.size(), 2064);
        chk("limit result", g, 1);
        $display("frame limit test done");
        tally_and_finish();
    end
endmodule : serial_link_frame_crc_test
